/* File: rtl/mrea_pkg.sv */
// Package of constants for the monitor reset, error and alert control.
// Assumes a single 50 MHz core clock and plain-port control bits.
package mrea_pkg;
   // Clock and round-robin timing
   localparam int unsigned CLK_NS     = 20;
   localparam int unsigned RR_MAX_MS  = 100;
   localparam int unsigned N_CH       = 19;
   localparam int unsigned RR_CYC     = RR_MAX_MS * 1000000 / CLK_NS;
   // Slot rounds down so a full pass stays under the limit
   localparam int unsigned SLOT_CYC   = (RR_CYC - 1) / N_CH;
   localparam int unsigned N_TEMP     = 3;
   localparam logic [4:0]  CH_LAST    = 5'h12;
   // Power-on reset pulse length on the reset pin
   localparam logic [4:0]  POR_HOLD   = 5'h10;
   // Limit table: channels, tach limits, user throttle limit
   localparam int unsigned N_LIM      = 24;
   localparam int unsigned L_TACH     = 19;
   localparam int unsigned L_UTH      = 23;
   localparam logic [7:0]  VLIM_RST   = 8'hff;
   localparam logic [7:0]  TLIM_RST   = 8'h80;
   localparam logic [7:0]  RD_EMPTY   = 8'h00;
   // Error event vector layout
   localparam int unsigned E_DIO      = 19;
   localparam int unsigned E_GPI      = 21;
   localparam int unsigned E_TACH     = 29;
   localparam int unsigned E_TERM     = 33;
   localparam int unsigned E_VRH      = 35;
   localparam int unsigned E_TT       = 37;
   localparam int unsigned E_UTH      = 39;
   localparam int unsigned N_EV       = 40;
   // Slave addresses per address-select level
   localparam logic [6:0]  ADR_LO     = 7'h2c;
   localparam logic [6:0]  ADR_MID    = 7'h2e;
   localparam logic [6:0]  ADR_HI     = 7'h2d;
   localparam logic [1:0]  SEL_LO     = 2'h0;
   localparam logic [1:0]  SEL_MID    = 2'h1;
   // Sleep states; deep sleep is the fourth/fifth state
   localparam logic [2:0]  SLP_RUN    = 3'h0;
   localparam logic [2:0]  SLP_DEEP   = 3'h4;
   // Sleep mask bits and other mask fields
   localparam int unsigned SM_GPI     = 0;
   localparam int unsigned SM_TEMP    = 1;
   localparam int unsigned OM_TERM    = 0;
   localparam int unsigned OM_VRH     = 2;
   localparam int unsigned OM_TT      = 4;
endpackage : mrea_pkg

/* File: rtl/mrea_seq_if.sv */
// Interface carrying the round-robin slot strobe between sequencer and core.
// Assumes both ends sit on the one core clock.
`timescale 1ns/100ps
`default_nettype none
interface mrea_seq_if;
   logic       go;
   logic [4:0] chan;
   logic       wrap;
   modport seq  (output go, output chan, output wrap);
   modport core (input go, input chan, input wrap);
endinterface : mrea_seq_if
`default_nettype wire

/* File: rtl/mrea_rr_seq.sv */
// Round-robin conversion sequencer: one slot per channel, fixed order.
// Assumes synchronous active-high reset; slot length comes from the top.
`timescale 1ns/100ps
`default_nettype none
module mrea_rr_seq
   import mrea_pkg::*;
#(
   parameter int unsigned SLOT = SLOT_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   mrea_seq_if.seq   sq
);
   logic [18:0] tmr_q;
   logic [4:0]  chan_q;
   logic        go_q;

   // Slot timer; counting restarts at power-up so the first sample starts one slot later
   always_ff @(posedge clk) begin
      if (rst || tmr_q == 19'(SLOT - 1)) begin
         tmr_q <= 19'h0;
      end else begin
         tmr_q <= tmr_q + 19'h1;
      end
   end

   // Channel walks zones 1-3 then analog inputs 1-16
   always_ff @(posedge clk) begin
      if (rst) begin
         chan_q <= 5'h0;
         go_q   <= 1'b0;
      end else begin
         go_q <= (tmr_q == 19'(SLOT - 1));
         if (go_q) begin
            chan_q <= (chan_q == CH_LAST) ? 5'h0 : chan_q + 5'h1;
         end
      end
   end

   assign sq.go   = go_q;
   assign sq.chan = chan_q;
   assign sq.wrap = go_q && chan_q == CH_LAST;

   // Pass wraps from the last channel back to the first; slot strobes never come closer than three cycles
   rr_wrap_a: assert property (@(posedge clk) disable iff (rst)
      go_q && chan_q == CH_LAST |=> chan_q == 5'h0)
      else $error("round robin did not wrap to channel one");
   rr_step_a: assert property (@(posedge clk) disable iff (rst)
      go_q |=> !go_q [*2])
      else $error("slot strobe repeated too early");
endmodule : mrea_rr_seq
`default_nettype wire

/* File: rtl/mrea_ctrl.sv */
// Reset, address, conversion sequencing and error status/alert control.
// Assumes rst is the power-on reset; SMBus, ADC and register access logic
// sit outside and reach this block through plain strobes on clk.
// Functional notes
// - Drive reset pin low at power-on
// - Pin becomes input; assertion clears lock
// - External reset forces deep sleep state
// - Power-on resets setup, masks; values untouched
// - Power-on clears global mask; external sets it
// - Latch slave address on first transaction
// - Fixed round robin over 19 channels
// - Full round robin under 100 ms
// - Results stored, readable any time
// - Duplicated sticky status, management and host
// - Write one clears only inactive events
// - Clearing one group leaves other untouched
// - ASF mode: management reads clear status
// - Masked events never set status bits
// - Voltage high limit FFh masks channel
// - Temp limit 80h masks temp, diode fault
// - GPI mask bits mask pin events
// - User limit FFh masks; predefined never alert
// - Tach limit FFh masks tach error
// - Own mask bits for termination, overheat
// - Alert disabled until enable bit set
// - Sleep state gates always/optional masking
// - Unimplemented read index returns 00h
`timescale 1ns/100ps
`default_nettype none
module mrea_ctrl
   import mrea_pkg::*;
#(
   parameter int unsigned SLOT = SLOT_CYC
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              reset_n_in,
   output logic                   reset_n_out,
   output logic                   reset_n_oe_n,
   input  wire logic [1:0]        addr_sel_lvl,
   input  wire logic              smb_first,
   output logic [6:0]             slave_addr_q,
   output logic                   addr_valid_q,
   output logic                   adc_start_q,
   output logic [4:0]             adc_chan_q,
   input  wire logic              adc_done,
   input  wire logic [7:0]        adc_data,
   input  wire logic [4:0]        rd_idx,
   output logic [7:0]             rd_data_q,
   input  wire logic              cfg_wr,
   input  wire logic              cfg_lock,
   input  wire logic              cfg_alert_en,
   input  wire logic              cfg_global_error_mask_bit,
   input  wire logic              cfg_asf,
   input  wire logic              slp_wr,
   input  wire logic [2:0]        slp_state,
   input  wire logic              msk_wr,
   input  wire logic [1:0]        msk_sleep,
   input  wire logic [7:0]        msk_gpi,
   input  wire logic [5:0]        msk_other,
   input  wire logic              lim_wr,
   input  wire logic [4:0]        lim_idx,
   input  wire logic [7:0]        lim_data,
   input  wire logic [1:0]        diode_fault,
   input  wire logic [7:0]        gpi_in,
   input  wire logic [3:0]        tach_err,
   input  wire logic [1:0]        bus_termination_input,
   input  wire logic [1:0]        regulator_overheat_signal,
   input  wire logic [1:0]        thermal_trip_input,
   input  wire logic              processor_throttle_signal,
   input  wire logic [1:0]        pred_throttle,
   input  wire logic              mgmt_clr_wr,
   input  wire logic              host_clr_wr,
   input  wire logic [N_EV-1:0]   clr_bits,
   input  wire logic              mgmt_rd,
   input  wire logic [2:0]        mgmt_rd_sel,
   input  wire logic              pred_clr,
   output logic [N_EV-1:0]        mgmt_status_q,
   output logic [N_EV-1:0]        host_status_q,
   output logic [1:0]             pred_status_q,
   output logic                   mgmt_error_output,
   output logic                   host_err_q,
   output logic                   alert_q,
   output logic                   lock_q,
   output logic                   global_error_mask_bit_q,
   output logic [2:0]             sleep_state_q
);
   logic [4:0]      por_cnt_q;
   logic            por_done_q;
   logic [1:0]      rpin_q;
   logic [1:0]      asel0_q;
   logic [1:0]      asel1_q;
   logic [7:0]      gpi0_q;
   logic [7:0]      gpi1_q;
   logic            alert_en_q;
   logic            asf_q;
   logic [1:0]      sm_q;
   logic [7:0]      gm_q;
   logic [5:0]      om_q;
   logic [7:0]      lim_q [N_LIM];
   logic [7:0]      val_q [N_CH];
   logic            ext_rst;
   logic [N_EV-1:0] evt;
   logic [N_EV-1:0] msk;
   logic [N_EV-1:0] set_v;
   logic [N_EV-1:0] mclr;
   logic [N_EV-1:0] hclr;
   logic            slp_any;
   logic            slp_deep;
   mrea_seq_if sq ();
   // Eight-bit slice of the status vector picked by a read select
   function automatic logic [N_EV-1:0] sl_mask(input logic [2:0] sel);
      sl_mask = N_EV'(64'hff << {sel, 3'h0});
   endfunction : sl_mask
   mrea_rr_seq #(
      .SLOT (SLOT)
   ) u_seq (
      .clk (clk),
      .rst (rst),
      .sq  (sq.seq)
   );
   // Power-on pulse on the open-drain reset pin, then release
   always_ff @(posedge clk) begin
      if (rst) begin
         por_cnt_q  <= 5'h0;
         por_done_q <= 1'b0;
      end else if (!por_done_q) begin
         por_cnt_q  <= por_cnt_q + 5'h1;
         por_done_q <= (por_cnt_q == POR_HOLD + 5'h2); // Synchroniser catch-up
      end
   end

   // Pin is only pulled low; the pull-up supplies the high level
   always_ff @(posedge clk) begin
      if (rst) begin
         reset_n_oe_n <= 1'b0;
         reset_n_out  <= 1'b0;
      end else begin
         reset_n_oe_n <= por_done_q || (por_cnt_q >= POR_HOLD - 5'h1);
         reset_n_out  <= 1'b0;
      end
   end

   // Pin and strap synchronisers
   always_ff @(posedge clk) begin
      rpin_q  <= {rpin_q[0], reset_n_in};
      asel0_q <= addr_sel_lvl;
      asel1_q <= asel0_q;
      gpi0_q  <= gpi_in;
      gpi1_q  <= gpi0_q;
   end

   // Done lags release until the synchroniser sees the pin high again
   assign ext_rst = por_done_q && reset_n_oe_n && !rpin_q[1];

   // Address is fixed at the first transaction and not re-sampled until the next power-on reset
   always_ff @(posedge clk) begin
      if (rst) begin
         slave_addr_q <= ADR_LO;
         addr_valid_q <= 1'b0;
      end else if (smb_first && !addr_valid_q) begin
         addr_valid_q <= 1'b1;
         case (asel1_q)
            SEL_LO:  slave_addr_q <= ADR_LO;
            SEL_MID: slave_addr_q <= ADR_MID;
            default: slave_addr_q <= ADR_HI;
         endcase
      end
   end

   // Configuration bits: lock, global mask, alert enable, ASF
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_q     <= 1'b0;
         global_error_mask_bit_q     <= 1'b0;
         alert_en_q <= 1'b0;
         asf_q      <= 1'b0;
      end else if (ext_rst) begin
         lock_q <= 1'b0;
         global_error_mask_bit_q <= 1'b1;
      end else if (cfg_wr) begin
         lock_q     <= lock_q | cfg_lock;
         global_error_mask_bit_q     <= cfg_global_error_mask_bit;
         alert_en_q <= cfg_alert_en;
         asf_q      <= cfg_asf;
      end
   end

   // Sleep state survives power-on reset; external reset forces deep
   always_ff @(posedge clk) begin
      if (ext_rst) begin
         sleep_state_q <= SLP_DEEP;
      end else if (slp_wr) begin
         sleep_state_q <= slp_state;
      end
   end

   // Mask registers: reset by power-on, frozen while locked
   always_ff @(posedge clk) begin
      if (rst) begin
         sm_q <= 2'h0;
         gm_q <= 8'h0;
         om_q <= 6'h0;
      end else if (msk_wr && !lock_q) begin
         sm_q <= msk_sleep;
         gm_q <= msk_gpi;
         om_q <= msk_other;
      end
   end

   // Limits reset to their masking values
   generate
      for (genvar i = 0; i < N_LIM; i++) begin : g_lim
         always_ff @(posedge clk) begin
            if (rst) begin
               lim_q[i] <= (i < N_TEMP) ? TLIM_RST : VLIM_RST;
            end else if (lim_wr && !lock_q && lim_idx == 5'(i)) begin
               lim_q[i] <= lim_data;
            end
         end
      end
   endgenerate

   // Value registers have no reset at all; any reset leaves them
   always_ff @(posedge clk) begin
      if (adc_done) begin
         val_q[adc_chan_q] <= adc_data;
      end
   end

   // Conversion request follows the sequencer slot
   always_ff @(posedge clk) begin
      if (rst) begin
         adc_start_q <= 1'b0;
         adc_chan_q  <= 5'h0;
      end else begin
         adc_start_q <= sq.go;
         if (sq.go) begin
            adc_chan_q <= sq.chan;
         end
      end
   end

   // Value reads never wait on the sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q <= RD_EMPTY;
      end else if (rd_idx < 5'(N_CH)) begin
         rd_data_q <= val_q[rd_idx];
      end else begin
         rd_data_q <= RD_EMPTY;
      end
   end

   // Raw events: channel over-limit, temps compared signed
   generate
      for (genvar c = 0; c < N_CH; c++) begin : g_cmp
         if (c < N_TEMP) begin : g_t
            assign evt[c] = $signed(val_q[c]) > $signed(lim_q[c]);
            assign msk[c] = lim_q[c] == TLIM_RST
                            || (slp_any && sm_q[SM_TEMP]) || global_error_mask_bit_q;
         end else begin : g_v
            assign evt[c] = val_q[c] > lim_q[c];
            assign msk[c] = lim_q[c] == VLIM_RST || slp_deep || global_error_mask_bit_q;
         end
      end
      for (genvar t = 0; t < 4; t++) begin : g_tach
         assign msk[E_TACH+t] = lim_q[L_TACH+t] == VLIM_RST
                                || slp_deep || global_error_mask_bit_q;
      end
   endgenerate

   assign slp_any  = sleep_state_q != SLP_RUN;
   assign slp_deep = sleep_state_q == SLP_DEEP;

   assign evt[E_DIO+:2]  = diode_fault;
   assign evt[E_GPI+:8]  = gpi1_q;
   assign evt[E_TACH+:4] = tach_err;
   assign evt[E_TERM+:2] = bus_termination_input;
   assign evt[E_VRH+:2]  = regulator_overheat_signal;
   assign evt[E_TT+:2]   = thermal_trip_input;
   assign evt[E_UTH]     = processor_throttle_signal;

   // Diode faults share the temperature channel mask
   assign msk[E_DIO+:2]  = msk[1:0];
   assign msk[E_GPI+:8]  = gm_q | {8{(slp_any && sm_q[SM_GPI]) || global_error_mask_bit_q}};
   assign msk[E_TERM+:2] = om_q[OM_TERM+:2] | {2{global_error_mask_bit_q}};
   assign msk[E_VRH+:2]  = om_q[OM_VRH+:2] | {2{global_error_mask_bit_q}};
   assign msk[E_TT+:2]   = om_q[OM_TT+:2] | {2{global_error_mask_bit_q}};
   assign msk[E_UTH]     = lim_q[L_UTH] == VLIM_RST || global_error_mask_bit_q;

   // Masked events cannot set, but masking never clears a bit
   assign set_v = evt & ~msk;
   assign mclr  = ((mgmt_clr_wr ? clr_bits : '0)
                | ((mgmt_rd && asf_q) ? sl_mask(mgmt_rd_sel) : '0)) & ~evt;
   assign hclr  = (host_clr_wr ? clr_bits : '0) & ~evt;

   // Two independent sticky groups; a set in the clear cycle wins
   always_ff @(posedge clk) begin
      if (rst) begin
         mgmt_status_q <= '0;
         host_status_q <= '0;
      end else begin
         mgmt_status_q <= (mgmt_status_q & ~mclr) | set_v;
         host_status_q <= (host_status_q & ~hclr) | set_v;
      end
   end

   // Predefined throttle flags: never masked, never on any error output
   always_ff @(posedge clk) begin
      if (rst) begin
         pred_status_q <= 2'h0;
      end else begin
         pred_status_q <= (pred_status_q & ~{2{pred_clr}}) | pred_throttle;
      end
   end

   // Error outputs and alert from set, unmasked bits
   always_ff @(posedge clk) begin
      if (rst) begin
         mgmt_error_output <= 1'b0;
         host_err_q        <= 1'b0;
         alert_q           <= 1'b0;
      end else begin
         mgmt_error_output <= |(mgmt_status_q & ~msk);
         host_err_q        <= |(host_status_q & ~msk);
         alert_q           <= alert_en_q && |(mgmt_status_q & ~msk);
      end
   end

   por_drive_a: assert property (@(posedge clk) disable iff (rst)
      !por_done_q && por_cnt_q < POR_HOLD - 5'h1 |-> !reset_n_oe_n && !reset_n_out)
      else $error("reset pin not driven during power-on pulse");
   lock_clear_a: assert property (@(posedge clk) disable iff (rst)
      ext_rst |=> !lock_q && global_error_mask_bit_q)
      else $error("external reset left lock or global mask wrong");
   sleep_deep_a: assert property (@(posedge clk) disable iff (rst)
      ext_rst |=> sleep_state_q == SLP_DEEP ##1 msk[3])
      else $error("external reset did not force deep sleep masking");
   addr_hold_a: assert property (@(posedge clk) disable iff (rst)
      addr_valid_q && $past(addr_valid_q) |-> $stable(slave_addr_q))
      else $error("slave address changed after latching");
   sticky_bit_a: assert property (@(posedge clk) disable iff (rst)
      !mgmt_clr_wr && !mgmt_rd |=> (mgmt_status_q & $past(mgmt_status_q))
                                   == $past(mgmt_status_q))
      else $error("management status bit dropped without a clear");
   active_keep_a: assert property (@(posedge clk) disable iff (rst)
      host_clr_wr && |(host_status_q & evt) |=> |host_status_q)
      else $error("host bit cleared while its event was active");
   host_indep_a: assert property (@(posedge clk) disable iff (rst)
      !host_clr_wr |=> (host_status_q & $past(host_status_q)) == $past(host_status_q))
      else $error("host status changed by a management clear");
   mask_set_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> (mgmt_status_q & ~$past(mgmt_status_q) & $past(msk)) == '0)
      else $error("masked event set a status bit");
   alert_off_a: assert property (@(posedge clk) disable iff (rst)
      !alert_en_q |=> !alert_q)
      else $error("alert raised while disabled");
   alert_follow_a: assert property (@(posedge clk) disable iff (rst)
      alert_en_q && |(mgmt_status_q & ~msk) |=> alert_q)
      else $error("alert missing for an unmasked status bit");
   empty_read_a: assert property (@(posedge clk) disable iff (rst)
      rd_idx >= 5'(N_CH) |=> rd_data_q == RD_EMPTY)
      else $error("unimplemented index did not read zero");
   pass_end_a: assert property (@(posedge clk) disable iff (rst)
      sq.wrap |=> adc_start_q && adc_chan_q == CH_LAST)
      else $error("last channel of a pass not converted");
endmodule : mrea_ctrl
`default_nettype wire

/* File: verif/mrea_adc_mdl.sv */
// Far-side converter model: answers every conversion start with a result.
// Assumes the one core clock; the result is 40h plus the channel number.
`timescale 1ns/100ps
`default_nettype none
module mrea_adc_mdl (
   input  wire logic       clk,
   input  wire logic       adc_start_q,
   input  wire logic [4:0] adc_chan_q,
   output logic            adc_done,
   output logic [7:0]      adc_data
);
   // Outputs start at zero; done stays low until the first start arrives
   initial begin
      adc_done = 1'b0;
      adc_data = 8'h00;
   end
   // Data toggles outside a result so a stale byte can never pass as new
   always @(posedge clk) begin
      adc_done <= adc_start_q;
      adc_data <= adc_start_q ? 8'h40 + {3'h0, adc_chan_q} : ~adc_data;
   end
endmodule : mrea_adc_mdl
`default_nettype wire

/* File: verif/monitor_reset_error_alert_ctrl_tb.sv */
// Testbench for the reset, error status and alert control block.
// Assumes the design package and the converter model beside the design.
`timescale 1ns/100ps
`default_nettype none
module monitor_reset_error_alert_ctrl_tb;
   import mrea_pkg::*;
   localparam logic [N_EV-1:0] B_TACH = 40'h1 << E_TACH;
   logic            clk = 1'b0, rst = 1'b1, ext_pin_n = 1'b1, smb_first = 1'b0;
   logic            cfg_wr = 1'b0, cfg_lock = 1'b0, cfg_alert_en = 1'b0, cfg_global_error_mask_bit = 1'b0;
   logic            cfg_asf = 1'b0, slp_wr = 1'b0, msk_wr = 1'b0, lim_wr = 1'b0;
   logic            mgmt_clr_wr = 1'b0, host_clr_wr = 1'b0, mgmt_rd = 1'b0, pred_clr = 1'b0;
   logic            processor_throttle_signal = 1'b0;
   logic [1:0]      addr_sel_lvl = SEL_MID, msk_sleep = 2'h0, diode_fault = 2'h0;
   logic [1:0]      bus_termination_input = 2'h0, regulator_overheat_signal = 2'h0;
   logic [1:0]      thermal_trip_input = 2'h0, pred_throttle = 2'h0;
   logic [2:0]      slp_state = 3'h0, mgmt_rd_sel = 3'h0;
   logic [3:0]      tach_err = 4'h0;
   logic [4:0]      rd_idx = 5'h00, lim_idx = 5'h00;
   logic [5:0]      msk_other = 6'h00;
   logic [7:0]      msk_gpi = 8'h00, lim_data = 8'h00, gpi_in = 8'h00;
   logic [N_EV-1:0] clr_bits = '0;
   logic            reset_n_out, reset_n_oe_n, addr_valid_q, adc_start_q, adc_done;
   // Open-drain reset pin: pull-up, our own drive and the board's switch
   wire logic       reset_n_in = ext_pin_n && (reset_n_oe_n || reset_n_out);
   logic            mgmt_error_output, host_err_q, alert_q, lock_q, global_error_mask_bit_q;
   logic [1:0]      pred_status_q;
   logic [2:0]      sleep_state_q;
   logic [4:0]      adc_chan_q;
   logic [6:0]      slave_addr_q;
   logic [7:0]      adc_data, rd_data_q;
   logic [N_EV-1:0] mgmt_status_q, host_status_q;
   int              miscompares = 0, n_compared = 0, c0;

   // Short slot keeps a full round robin pass to 152 cycles
   mrea_ctrl #(.SLOT(8)) DUT (.clk, .rst, .reset_n_in, .reset_n_out, .reset_n_oe_n,
      .addr_sel_lvl, .smb_first, .slave_addr_q, .addr_valid_q, .adc_start_q, .adc_chan_q,
      .adc_done, .adc_data, .rd_idx, .rd_data_q, .cfg_wr, .cfg_lock, .cfg_alert_en,
      .cfg_global_error_mask_bit, .cfg_asf, .slp_wr, .slp_state, .msk_wr, .msk_sleep, .msk_gpi, .msk_other,
      .lim_wr, .lim_idx, .lim_data, .diode_fault, .gpi_in, .tach_err,
      .bus_termination_input, .regulator_overheat_signal, .thermal_trip_input,
      .processor_throttle_signal, .pred_throttle, .mgmt_clr_wr, .host_clr_wr, .clr_bits,
      .mgmt_rd, .mgmt_rd_sel, .pred_clr, .mgmt_status_q, .host_status_q, .pred_status_q,
      .mgmt_error_output, .host_err_q, .alert_q, .lock_q, .global_error_mask_bit_q, .sleep_state_q);
   mrea_adc_mdl PM (.clk, .adc_start_q, .adc_chan_q, .adc_done, .adc_data);

   // 50 MHz core clock
   initial begin
      forever #10 clk = ~clk;
   end

   // Inputs always move one nanosecond after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [N_EV-1:0] seen, input logic [N_EV-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   // Write strobes: one cycle high, then time for status to follow
   task automatic cfg(input logic lk, input logic ae, input logic asf);
      {cfg_lock, cfg_alert_en, cfg_asf} = {lk, ae, asf};
      cfg_wr = 1'b1;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(2);
   endtask : cfg

   task automatic lim(input logic [4:0] idx, input logic [7:0] d);
      {lim_idx, lim_data, lim_wr} = {idx, d, 1'b1};
      cyc(1);
      lim_wr = 1'b0;
      cyc(2);
   endtask : lim

   task automatic msk(input logic [7:0] g, input logic [5:0] o);
      {msk_gpi, msk_other, msk_wr} = {g, o, 1'b1};
      cyc(1);
      msk_wr = 1'b0;
      cyc(2);
   endtask : msk

   task automatic clr(input logic host, input logic [N_EV-1:0] b);
      {clr_bits, mgmt_clr_wr, host_clr_wr} = {b, !host, host};
      cyc(1);
      {mgmt_clr_wr, host_clr_wr} = 2'b00;
      cyc(2);
   endtask : clr

   // Bounded wait for the next conversion start
   task automatic wait_start;
      int k;
      k = 0;
      while (adc_start_q !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      if (k >= 40) begin
         miscompares++;
         finish_test();
      end
   endtask : wait_start

   // Main sequence
   initial begin
      cyc(4);
      chk({reset_n_oe_n, reset_n_out}, 0);
      rst = 1'b0;
      cyc(10);
      chk(reset_n_oe_n, 0);
      cyc(8);
      chk(reset_n_oe_n, 1);
      chk({lock_q, global_error_mask_bit_q, alert_q}, 0);
      {slp_state, slp_wr} = {SLP_RUN, 1'b1};
      cyc(1);
      slp_wr = 1'b0;
      $display("test reset done");
      smb_first = 1'b1;
      cyc(1);
      smb_first = 1'b0;
      addr_sel_lvl = SEL_LO;
      cyc(2);
      chk({addr_valid_q, slave_addr_q}, {1'b1, ADR_MID});
      cyc(3);
      smb_first = 1'b1;
      cyc(1);
      smb_first = 1'b0;
      cyc(2);
      chk(slave_addr_q, ADR_MID);
      $display("test address done");
      wait_start();
      c0 = int'(adc_chan_q);
      for (int i = 0; i < 21; i++) begin
         chk(adc_chan_q, 40'((c0 + i) % N_CH));
         cyc(1);
         wait_start();
      end
      cyc(3);
      rd_idx = 5'h03;
      cyc(2);
      chk(rd_data_q, 8'h43);
      rd_idx = 5'h14;
      cyc(2);
      chk(rd_data_q, RD_EMPTY);
      $display("test conversion done");
      tach_err = 4'h1;
      cyc(3);
      chk(mgmt_status_q & B_TACH, 0);
      tach_err = 4'h0;
      lim(5'(L_TACH), 8'h10);
      tach_err = 4'h1;
      cyc(3);
      chk({mgmt_status_q[E_TACH], host_status_q[E_TACH]}, 2'b11);
      chk(alert_q, 0);
      cfg(1'b0, 1'b1, 1'b0);
      chk({mgmt_error_output, alert_q}, 2'b11);
      clr(1'b0, B_TACH);
      chk(mgmt_status_q & B_TACH, B_TACH);
      tach_err = 4'h0;
      cyc(2);
      chk(mgmt_status_q & B_TACH, B_TACH);
      clr(1'b0, B_TACH);
      chk({mgmt_status_q[E_TACH], host_status_q[E_TACH]}, 2'b01);
      chk(alert_q, 0);
      clr(1'b1, '0);
      chk(host_status_q & B_TACH, B_TACH);
      clr(1'b1, B_TACH);
      chk(host_status_q & B_TACH, 0);
      $display("test status done");
      msk(8'h01, 6'h00);
      gpi_in = 8'h03;
      cyc(6);
      chk(mgmt_status_q[E_GPI+:2], 2'b10);
      gpi_in = 8'h00;
      cyc(4);
      clr(1'b0, 40'h3 << E_GPI);
      bus_termination_input = 2'h1;
      cyc(3);
      bus_termination_input = 2'h0;
      cfg(1'b0, 1'b1, 1'b1);
      {mgmt_rd_sel, mgmt_rd} = {3'h4, 1'b1};
      cyc(1);
      mgmt_rd = 1'b0;
      cyc(2);
      chk({mgmt_status_q[E_TERM], host_status_q[E_TERM]}, 2'b01);
      msk(8'h01, 6'h05);
      chk(host_status_q[E_TERM], 1);
      {bus_termination_input, regulator_overheat_signal} = 4'h5;
      processor_throttle_signal = 1'b1;
      pred_throttle = 2'h1;
      cyc(3);
      chk({mgmt_status_q[E_TERM], mgmt_status_q[E_VRH]}, 0);
      chk({mgmt_status_q[E_UTH], pred_status_q[0]}, 2'b01);
      chk({mgmt_error_output, alert_q}, 0);
      chk(host_err_q, 1);
      pred_throttle = 2'h0;
      pred_clr = 1'b1;
      cyc(1);
      pred_clr = 1'b0;
      chk(pred_status_q, 0);
      $display("test masking done");
      cfg(1'b1, 1'b1, 1'b0);
      chk(lock_q, 1);
      ext_pin_n = 1'b0;
      cyc(4);
      ext_pin_n = 1'b1;
      cyc(3);
      chk({lock_q, global_error_mask_bit_q, sleep_state_q}, {2'b01, SLP_DEEP});
      $display("test external reset done");
      // Second power-on: values and sleep state survive, address re-latched
      rst = 1'b1;
      addr_sel_lvl = 2'h2;
      rd_idx = 5'h03;
      cyc(4);
      rst = 1'b0;
      cyc(1);
      chk({reset_n_oe_n, lock_q, global_error_mask_bit_q, sleep_state_q, rd_data_q},
          {3'b000, SLP_DEEP, 8'h43});
      smb_first = 1'b1;
      cyc(1);
      smb_first = 1'b0;
      cyc(1);
      chk(slave_addr_q, ADR_HI);
      $display("test second power-on done");
      finish_test();
   end
endmodule : monitor_reset_error_alert_ctrl_tb
`default_nettype wire
